// *** rtl/mdcs_clock_select.v ***
// Core and DMA clock source select with sleep control, APB register.
//
// Contract
// [R01] Idle plus sleep gates the ring oscillator first, then all oscillators.
// [R02] Idle plus sleep drives the active-low flash chip enable high.
// [R03] Ring enable bit starts or stops the ring; set it before selecting it.
// [R04] Source bit 0 picks the ring; 1 picks the rate field.
// [R05] Core rate field: 00 8, 01 12, 10 16, 11 24 MHz.
// [R06] DMA external bit picks the external clock pin, else the rate field.
// [R07] DMA rate field: 00 stopped, 01 2, 10 4, 11 8 MHz.
// [R08] Switching takes three old then three new clock pulses.
// [R09] Software waits after enabling the ring before selecting it.
// [R10] Software should trade clock speed against workload to save power.
// [R11] The ring clocks the core with crystal and PLL off; the code keeps crystal and PLL on whenever the ring runs.
// [R12] An unmasked wakeup restarts ring and crystal after a stop.
// [R13] Clock selection never emits runt or glitch pulses.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "mdcs_defs.vh"

module mdcs_clock_select #(
	parameter [7:0] RING_MHZ = `MDCS_RING_MHZ
) (
	input  wire        i_clk,
	input  wire        i_arst_n,
	input  wire        i_psel,
	input  wire        i_penable,
	input  wire        i_pwrite,
	input  wire [31:0] i_paddr,
	input  wire [31:0] i_pwdata,
	input  wire [3:0]  i_pstrb,
	output reg  [31:0] o_prdata,
	output wire        o_pready,
	output wire        o_pslverr,
	input  wire        i_core_idle_bit,
	input  wire        i_wakeup,
	input  wire        i_external_clock_input,
	output wire        o_core_clk_en,
	output wire        o_dma_clk_en,
	output reg         o_ring_osc_on,
	output reg         o_xtal_pll_on,
	output reg         o_flash_chip_enable_n
);

	// ------------------------------------------------------------------
	// Register and power state.
	// ------------------------------------------------------------------
	reg  [7:0] sel_reg;
	reg  [1:0] pstate;
	reg  [1:0] next_pstate;
	wire       core_busy;
	wire       dma_busy;

	wire ring_osc_enable    = sel_reg[`MDCS_B_RING_EN];
	wire core_clock_source  = sel_reg[`MDCS_B_CORE_SRC];
	wire dma_clock_external = sel_reg[`MDCS_B_DMA_EXT];
	wire [1:0] core_rate    = sel_reg[`MDCS_F_CORE_HI:`MDCS_F_CORE_LO];
	wire [1:0] dma_clock_rate = sel_reg[`MDCS_F_DMA_HI:`MDCS_F_DMA_LO];
	wire       sleep_bit    = sel_reg[`MDCS_B_SLEEP];

	// ------------------------------------------------------------------
	// APB slave: zero wait states, read data captured in the setup cycle.
	// ------------------------------------------------------------------
	wire hit_sel  = (i_paddr == `MDCS_SEL_ADDR);
	wire hit_stat = (i_paddr == `MDCS_STAT_ADDR);
	wire access   = i_psel && i_penable;
	wire wr_sel   = access && i_pwrite && hit_sel && i_pstrb[0];

	assign o_pready  = 1'b1;
	assign o_pslverr = access && !hit_sel && !hit_stat;

	// Read data is latched in the setup cycle and held through access.
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_prdata <= 32'h00000000;
		end else if (i_psel && !i_penable) begin
			if (hit_sel)
				o_prdata <= {24'h000000, sel_reg};
			else if (hit_stat)
				o_prdata <= {27'h0000000, pstate, dma_busy, core_busy,
				             o_xtal_pll_on};
			else
				o_prdata <= 32'h00000000;
		end
	end

	// Software writes the select byte; a wakeup outside the run state clears sleep and wins.
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sel_reg <= `MDCS_SEL_RESET;
		end else begin
			if (wr_sel)
				sel_reg <= i_pwdata[7:0];
			if (i_wakeup && pstate != `MDCS_PS_RUN)
				sel_reg[`MDCS_B_SLEEP] <= 1'b0; // [R12]
		end
	end

	// ------------------------------------------------------------------
	// Sleep sequencing: ring gated first, then every oscillator off.
	// ------------------------------------------------------------------
	always @* begin
		next_pstate = pstate;
		case (pstate)
		`MDCS_PS_RUN: begin
			if (i_core_idle_bit && sleep_bit)
				next_pstate = `MDCS_PS_GATE; // [R01]
		end
		`MDCS_PS_GATE: begin
			if (i_wakeup)
				next_pstate = `MDCS_PS_RUN; // [R12]
			else
				next_pstate = `MDCS_PS_OFF; // [R01]
		end
		`MDCS_PS_OFF: begin
			if (i_wakeup)
				next_pstate = `MDCS_PS_RUN; // [R12]
		end
		default: begin
			next_pstate = `MDCS_PS_RUN;
		end
		endcase
	end

	// Oscillator controls follow the next power state; flash enable follows idle and sleep.
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pstate                <= `MDCS_PS_RUN;
			o_ring_osc_on         <= 1'b0;
			o_xtal_pll_on         <= 1'b0;
			o_flash_chip_enable_n <= 1'b1;
		end else begin
			pstate        <= next_pstate;
			o_ring_osc_on <= ring_osc_enable &&
			                 next_pstate == `MDCS_PS_RUN; // [R03] [R01]
			o_xtal_pll_on <= next_pstate != `MDCS_PS_OFF; // [R01] [R12]
			o_flash_chip_enable_n <= i_core_idle_bit && sleep_bit; // [R02]
		end
	end

	// ------------------------------------------------------------------
	// Rate pulse generators: accumulators give exact average rates.
	// ------------------------------------------------------------------
	localparam [63:0] RATES = {RING_MHZ, `MDCS_RATE_TABLE};
	wire [7:0] rate_en;

	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_rate
			reg  [8:0] acc;
			wire [8:0] sum = acc + {1'b0, RATES[g*8 +: 8]};
			// The ring runs alone; the others need crystal and PLL.
			wire run = (g == 7) ? o_ring_osc_on : o_xtal_pll_on; // [R11]
			reg        pulse;
			always @(posedge i_clk or negedge i_arst_n) begin
				if (!i_arst_n) begin
					acc   <= 9'd0;
					pulse <= 1'b0;
				end else if (!run) begin
					acc   <= 9'd0;
					pulse <= 1'b0;
				end else if (sum >= `MDCS_BASE_MHZ) begin
					acc   <= sum - `MDCS_BASE_MHZ;
					pulse <= 1'b1;
				end else begin
					acc   <= sum;
					pulse <= 1'b0;
				end
			end
			// A stopped source drops a pulse still in its register.
			assign rate_en[g] = pulse && run; // [R01] [R11]
		end
	endgenerate

	// ------------------------------------------------------------------
	// External DMA clock: two-stage synchroniser, then rising edge.
	// ------------------------------------------------------------------
	reg ext_s1;
	reg ext_s2;
	reg ext_s3;
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ext_s1 <= 1'b0;
			ext_s2 <= 1'b0;
			ext_s3 <= 1'b0;
		end else begin
			ext_s1 <= i_external_clock_input;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
		end
	end
	wire ext_en = ext_s2 && !ext_s3;

	// ------------------------------------------------------------------
	// Source selection through the glitch-free switches.
	// ------------------------------------------------------------------
	wire [2:0] core_sel = core_clock_source ?
	                      {1'b0, core_rate} + 3'd1 : 3'd0; // [R04] [R05]
	wire [2:0] dma_sel  = dma_clock_external ?
	                      3'd4 : {1'b0, dma_clock_rate}; // [R06] [R07]

	// Core sources: ring, then 8, 12, 16 and 24 MHz.
	mdcs_switch #(
		.N  (5),
		.SW (3)
	) u_core_sw (
		.i_clk      (i_clk),
		.i_arst_n   (i_arst_n),
		.i_sel      (core_sel),
		.i_src_en   ({rate_en[3:0], rate_en[7]}),
		.i_src_live ({{4{o_xtal_pll_on}}, o_ring_osc_on}),
		.o_clk_en   (o_core_clk_en), // [R08] [R13]
		.o_busy     (core_busy)
	);

	// DMA sources: stopped, 2, 4, 8 MHz, then the external pin.
	mdcs_switch #(
		.N  (5),
		.SW (3)
	) u_dma_sw (
		.i_clk      (i_clk),
		.i_arst_n   (i_arst_n),
		.i_sel      (dma_sel),
		.i_src_en   ({ext_en, rate_en[6:4], 1'b0}),
		.i_src_live ({1'b1, {3{o_xtal_pll_on}}, 1'b0}),
		.o_clk_en   (o_dma_clk_en), // [R08] [R13]
		.o_busy     (dma_busy)
	);

endmodule // mdcs_clock_select

`default_nettype wire

// *** rtl/mdcs_defs.vh ***
// Constants for the core and DMA clock select block.
`ifndef MDCS_DEFS_VH
`define MDCS_DEFS_VH

// ----------------------------------------------------------------------
// Register map: index as printed, byte address is four times the index.
// ----------------------------------------------------------------------
`define MDCS_SEL_IDX      17'h07f27
`define MDCS_STAT_IDX     17'h07f3f
`define MDCS_SEL_ADDR     32'h0001fc9c
`define MDCS_STAT_ADDR    32'h0001fcfc
`define MDCS_SEL_RESET    8'h40

// ----------------------------------------------------------------------
// Field positions of the clock select register.
// ----------------------------------------------------------------------
`define MDCS_B_SLEEP      7
`define MDCS_B_RING_EN    6
`define MDCS_B_CORE_SRC   5
`define MDCS_F_CORE_HI    4
`define MDCS_F_CORE_LO    3
`define MDCS_B_DMA_EXT    2
`define MDCS_F_DMA_HI     1
`define MDCS_F_DMA_LO     0

// ----------------------------------------------------------------------
// Rates in MHz and the base clock.
// ----------------------------------------------------------------------
`define MDCS_BASE_MHZ     9'd200
`define MDCS_RING_MHZ     8'd8
`define MDCS_RATE_TABLE   {8'd8, 8'd4, 8'd2, 8'd24, 8'd16, 8'd12, 8'd8}

// ----------------------------------------------------------------------
// Switch timing: pulses of the old clock, then of the new clock.
// ----------------------------------------------------------------------
`define MDCS_OLD_PULSES   2'd3
`define MDCS_NEW_PULSES   2'd3

// ----------------------------------------------------------------------
// Power states.
// ----------------------------------------------------------------------
`define MDCS_PS_RUN       2'b00
`define MDCS_PS_GATE      2'b01
`define MDCS_PS_OFF       2'b10

`endif

// *** rtl/mdcs_switch.v ***
// Glitch-free selector of clock enable pulses.
`timescale 1ns/1ps
`default_nettype none
`include "mdcs_defs.vh"

module mdcs_switch #(
	parameter N  = 5,
	parameter SW = 3
) (
	input  wire          i_clk,
	input  wire          i_arst_n,
	input  wire [SW-1:0] i_sel,
	input  wire [N-1:0]  i_src_en,
	input  wire [N-1:0]  i_src_live,
	output wire          o_clk_en,
	output wire          o_busy
);

	localparam ST_PASS = 2'b00;
	localparam ST_OLD  = 2'b01;
	localparam ST_NEW  = 2'b10;

	reg [SW-1:0] cur;
	reg [1:0]    state;
	reg [1:0]    cnt;

	// Walks old-clock pulses, then new-clock pulses, output blocked.
	// A stopped old source cannot count, so its wait is skipped.
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cur   <= {SW{1'b0}};
			state <= ST_PASS;
			cnt   <= 2'd0;
		end else begin
			case (state)
			ST_PASS: begin
				if (i_sel != cur) begin
					cnt   <= 2'd0;
					state <= i_src_live[cur] ? ST_OLD : ST_NEW;
					if (!i_src_live[cur])
						cur <= i_sel;
				end
			end
			ST_OLD: begin
				if (i_src_en[cur]) begin
					if (cnt == `MDCS_OLD_PULSES - 2'd1) begin
						cnt   <= 2'd0;
						cur   <= i_sel;
						state <= ST_NEW;
					end else begin
						cnt <= cnt + 2'd1;
					end
				end
			end
			ST_NEW: begin
				if (i_src_en[cur] || !i_src_live[cur]) begin
					if (cnt == `MDCS_NEW_PULSES - 2'd1 ||
					    !i_src_live[cur]) begin
						cnt   <= 2'd0;
						state <= ST_PASS;
					end else begin
						cnt <= cnt + 2'd1;
					end
				end
			end
			default: begin
				state <= ST_PASS;
			end
			endcase
		end
	end

	// Pulses pass only once the switch has settled.
	assign o_clk_en = (state == ST_PASS) && (i_sel == cur) && i_src_en[cur];
	assign o_busy   = (state != ST_PASS) || (i_sel != cur);

endmodule // mdcs_switch

`default_nettype wire

// *** testbench/mdcs_clock_select_monitor.sv ***
// Port checker of the clock select block.
`timescale 1ns/1ps
`default_nettype none
`include "mdcs_defs.vh"
// ------------------------------------------------------------
// Checker
// ------------------------------------------------------------
module mdcs_clock_select_monitor (
	input wire logic        i_clk,
	input wire logic        i_arst_n,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic [31:0] i_paddr,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pslverr,
	input wire logic        i_core_idle_bit,
	input wire logic        i_wakeup,
	input wire logic        o_core_clk_en,
	input wire logic        o_dma_clk_en,
	input wire logic        o_ring_osc_on,
	input wire logic        o_xtal_pll_on,
	input wire logic        o_flash_chip_enable_n
);
	// One clock domain with its asynchronous reset.
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	// Quiet spans that follow a pulse at the fastest rates.
	sequence s_core_gap; !o_core_clk_en [*7]; endsequence
	sequence s_dma_gap; !o_dma_clk_en [*8]; endsequence
	property p_err_map;
		i_psel && i_penable |-> o_pslverr == (i_paddr !=
			`MDCS_SEL_ADDR && i_paddr != `MDCS_STAT_ADDR);
	endproperty
	a_err_map: assert property (p_err_map)
		else $error("bad slave error");
	property p_err_data;
		i_psel && i_penable && o_pslverr |-> o_prdata == 32'h0;
	endproperty
	a_err_data: assert property (p_err_data)
		else $error("bad error data");
	property p_core_gap;
		o_core_clk_en |=> s_core_gap;
	endproperty
	a_core_gap: assert property (p_core_gap)
		else $error("core runt pulse");
	property p_dma_gap;
		o_dma_clk_en |=> s_dma_gap;
	endproperty
	a_dma_gap: assert property (p_dma_gap)
		else $error("dma runt pulse");
	property p_gate_order;
		$fell(o_xtal_pll_on) |-> !$past(o_ring_osc_on);
	endproperty
	a_gate_order: assert property (p_gate_order)
		else $error("xtal off before ring");
	property p_all_off;
		!o_ring_osc_on && !o_xtal_pll_on |-> !o_core_clk_en;
	endproperty
	a_all_off: assert property (p_all_off)
		else $error("core pulse with all off");
	property p_flash;
		$rose(o_flash_chip_enable_n) |-> $past(i_core_idle_bit);
	endproperty
	a_flash: assert property (p_flash)
		else $error("flash off without idle");
	property p_wake;
		i_wakeup && !o_xtal_pll_on |-> ##[1:3] o_xtal_pll_on;
	endproperty
	a_wake: assert property (p_wake)
		else $error("no restart on wakeup");
endmodule // mdcs_clock_select_monitor

bind mdcs_clock_select mdcs_clock_select_monitor u_mon (
	.i_clk(i_clk), .i_arst_n(i_arst_n), .i_psel(i_psel),
	.i_penable(i_penable), .i_paddr(i_paddr), .o_prdata(o_prdata),
	.o_pslverr(o_pslverr), .i_core_idle_bit(i_core_idle_bit),
	.i_wakeup(i_wakeup), .o_core_clk_en(o_core_clk_en),
	.o_dma_clk_en(o_dma_clk_en), .o_ring_osc_on(o_ring_osc_on),
	.o_xtal_pll_on(o_xtal_pll_on),
	.o_flash_chip_enable_n(o_flash_chip_enable_n));
`default_nettype wire

// *** testbench/mdcs_clock_select_test.sv ***
// Self-checking bench of the clock select block.
`timescale 1ns/1ps
`default_nettype none
`include "mdcs_defs.vh"
// ------------------------------------------------------------
// Bench
// ------------------------------------------------------------
module mdcs_clock_select_test;
	localparam logic [7:0] RING = 8'd10;
	logic        clk = 1'b0, arst_n = 1'b0, ext = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        idle = 1'b0, wake = 1'b0, er;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
	logic [3:0]  pstrb = 4'h0;
	logic        pready, pslverr, core_en, dma_en;
	logic        ring_on, xtal_on, flash_n;
	int          n_fail = 0, comparisons = 0, c, d, i;
	logic [7:0]  tv [7] = '{8'h60, 8'h69, 8'h72, 8'h7b, 8'h5b,
		8'h5f, 8'h1f};
	int          tc [7] = '{24, 36, 48, 72, 3*RING, 3*RING, 0};
	int          td [7] = '{0, 6, 12, 24, 24, 15, 15};
	logic [1:0]  tb [7] = '{2'h1, 2'h3, 2'h3, 2'h3, 2'h1, 2'h2, 2'h0};

	mdcs_clock_select #(.RING_MHZ(RING)) u_mdcs_clock_select (
		.i_clk(clk), .i_arst_n(arst_n), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr),
		.i_core_idle_bit(idle), .i_wakeup(wake),
		.i_external_clock_input(ext), .o_core_clk_en(core_en),
		.o_dma_clk_en(dma_en), .o_ring_osc_on(ring_on),
		.o_xtal_pll_on(xtal_on), .o_flash_chip_enable_n(flash_n));

	// Clock at 200 MHz and an external pin with a 40-cycle period.
	always #2.5 clk = ~clk;
	always begin
		repeat (20) @(posedge clk);
		ext <= ~ext;
	end

	// One APB transfer; read data and error taken at the access edge.
	task automatic apb(input logic w, input logic [31:0] a,
		input logic [7:0] v, input logic [3:0] s);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, v};
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk(input string n, input logic [31:0] s, e);
		comparisons++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %s exp %h seen %h", n, e, s);
		end
	endtask

	// Counts enable pulses over 600 cycles, three microseconds.
	task automatic cnt;
		c = 0;
		d = 0;
		repeat (600) begin
			@(negedge clk);
			c += (core_en === 1'b1);
			d += (dma_en === 1'b1);
		end
	endtask

	task automatic wrap_up;
		if (n_fail == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Cuts a hang short.
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		wrap_up;
	end

	// Main sequence: register access, rates, sleep and wakeup.
	initial begin
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		apb(0, `MDCS_SEL_ADDR, 8'h0, 4'h1);
		chk("sel", rd, 32'h40);
		apb(0, `MDCS_STAT_ADDR, 8'h0, 4'h1);
		chk("stat", rd[4:0], 5'h01);
		apb(1, `MDCS_SEL_ADDR, 8'h0, 4'h0);
		apb(1, `MDCS_STAT_ADDR, 8'hff, 4'h1);
		chk("ro err", er, 1'b0);
		apb(0, `MDCS_SEL_ADDR, 8'h0, 4'h1);
		chk("sel kept", rd, 32'h40);
		apb(0, 32'h100, 8'h0, 4'h1);
		chk("bad err", er, 1'b1);
		chk("bad data", rd, 32'h0);
		for (i = 0; i < 7; i++) begin
			apb(1, `MDCS_SEL_ADDR, tv[i], 4'h1);
			apb(0, `MDCS_STAT_ADDR, 8'h0, 4'h1);
			chk("busy", rd[2:1], tb[i]);
			repeat (500) @(posedge clk);
			apb(0, `MDCS_STAT_ADDR, 8'h0, 4'h1);
			chk("settled", rd[2:1], 2'h0);
			apb(0, `MDCS_SEL_ADDR, 8'h0, 4'h1);
			chk("sel", rd, tv[i]);
			cnt;
			chk("core", c, tc[i]);
			chk("dma", d, td[i]);
		end
		@(posedge clk);
		idle <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk("idle", flash_n, 1'b0);
		apb(1, `MDCS_SEL_ADDR, 8'hdf, 4'h1);
		repeat (4) @(posedge clk);
		#1;
		chk("flash", flash_n, 1'b1);
		chk("ring", ring_on, 1'b0);
		chk("xtal", xtal_on, 1'b0);
		apb(0, `MDCS_STAT_ADDR, 8'h0, 4'h1);
		chk("off", rd[4:3], 2'h2);
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
		chk("ring up", ring_on, 1'b1);
		chk("xtal up", xtal_on, 1'b1);
		chk("flash up", flash_n, 1'b0);
		apb(0, `MDCS_SEL_ADDR, 8'h0, 4'h1);
		chk("woken", rd, 32'h5f);
		wrap_up;
	end
endmodule // mdcs_clock_select_test
`default_nettype wire
